// ==== rtl/gpr_cfg.svh ====
// Constants of the pin port register block: map, fields, reset values.
`ifndef GPR_CFG_SVH
`define GPR_CFG_SVH

`define GPR_NPIN         26
`define GPR_BASE_ADDR    32'h4000_0000
`define GPR_DECODE_MASK  32'hFFFF_FF00

`define GPR_OFF_DATA     8'h00
`define GPR_OFF_DIR      8'h04
`define GPR_OFF_PULL     8'h08
`define GPR_OFF_DRIVE    8'h0C
`define GPR_OFF_SENSE    8'h10
`define GPR_OFF_BOTH     8'h14
`define GPR_OFF_POL      8'h18
`define GPR_OFF_MASK     8'h1C
`define GPR_OFF_RAW      8'h20
`define GPR_OFF_MASKED   8'h24
`define GPR_OFF_ICLR     8'h28
`define GPR_OFF_FSEL0    8'h2C
`define GPR_OFF_FSEL1    8'h30
`define GPR_OFF_FSEL2    8'h34
`define GPR_OFF_FSEL3    8'h38
`define GPR_OFF_SET      8'h3C
`define GPR_OFF_CLR      8'h40
`define GPR_OFF_CAPSEL   8'h44

`define GPR_RST_PINS     26'h000_0000
`define GPR_RST_PULL     26'h3FF_FFFF
`define GPR_RST_FSEL1    32'h0000_0110
`define GPR_RST_WORD     32'h0000_0000

`define GPR_FSEL_PORT    3'h0
`define GPR_FSEL_ALT1    3'h1
`define GPR_FSEL_ALT0    3'h4
`define GPR_FSEL_ALT2    3'h5
`define GPR_FSEL_STRIDE  4
`define GPR_FSEL_PER_REG 8

`endif

// ==== rtl/gpr_pkg.sv ====
// Types shared by the pin port register block.
`include "gpr_cfg.svh"

package gpr_pkg;

    typedef logic [`GPR_NPIN-1:0] gpr_pins_t;
    typedef logic [2:0]           gpr_fsel_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic        we;
        logic        re;
    } gpr_bus_req_t;

    typedef struct packed {
        gpr_pins_t out;
        gpr_pins_t oe;
    } gpr_alt_t;

    typedef struct packed {
        gpr_pins_t out;
        gpr_pins_t oe;
        gpr_pins_t pull;
        gpr_pins_t drive_high;
    } gpr_pad_t;

endpackage

// ==== rtl/gpr_top.sv ====
// Pin port register block: registers, pin multiplexer, pin events.
//
// The address-and-strobe port was chosen for this implementation.
`include "gpr_cfg.svh"

// Notes on behaviour
// RQ1 - Registers answer at the base address plus their offset only.
// RQ2 - Data bits drive pins that are in port function and set as outputs.
// RQ3 - Reading the data register returns the sampled pin levels.
// RQ4 - Direction bit 0 is input, 1 is output; resets to all inputs.
// RQ5 - Pull enable bit 1 enables the pull; resets with all pulls on; here the pad pull outputs stay off until one clock after reset ends.
// RQ6 - Drive bit 0 is low drive, 1 is high drive; resets low.
// RQ7 - Sense bit 0 detects edges, 1 detects levels.
// RQ8 - Edge bit 0 detects a single edge, 1 detects both edges.
// RQ9 - Polarity bit 0 means falling or low, 1 rising or high.
// RQ10 - Mask bit 1 enables the pin interrupt, 0 keeps it off.
// RQ11 - Raw status is read only, one bit per pin, resets to zero.
// RQ12 - Masked status is read only, one bit per pin, resets to zero.
// RQ13 - Interrupt clear is write only; a one clears the pending bit.
// RQ14 - Function codes: port, alternate one, zero, two; first register 0-7.
// RQ15 - Second function register covers 8-15, pins 9 and 10 start alternate.
// RQ16 - Third function register covers 16-23, fourth 24-25, reset to port.
// RQ17 - Set register ones set data bits of port function pins.
// RQ18 - Clear register ones clear data bits of port function pins.
// RQ19 - Capture select register chooses timer capture pins; resets to zero.
// RQ20 - Raw bit sets whenever the pin matches its chosen condition; here only while the pin is in port function.
// RQ21 - Masked status equals mask AND raw status.
// RQ22 - All masked pin interrupts merge into one request line.
// RQ23 - Bits above pin 25 read as zero and ignore writes.
module gpr_top #(
    parameter logic [31:0] BASE_ADDR   = `GPR_BASE_ADDR,
    parameter logic [31:0] DECODE_MASK = `GPR_DECODE_MASK
) (
    input  wire logic                 clk_i,
    input  wire logic                 reset_n_i,
    input  wire gpr_pkg::gpr_bus_req_t bus_req_i,
    output logic [31:0]               bus_rdata_o,
    input  wire gpr_pkg::gpr_pins_t   pin_level_i,
    input  wire gpr_pkg::gpr_alt_t    alt_zero_i,
    input  wire gpr_pkg::gpr_alt_t    alt_one_i,
    input  wire gpr_pkg::gpr_alt_t    alt_two_i,
    output gpr_pkg::gpr_pad_t         pad_o,
    output gpr_pkg::gpr_pins_t        pin_sampled_o,
    output logic [31:0]               capture_select_o,
    output logic                      irq_o
);
    import gpr_pkg::*;

    localparam int NPIN = `GPR_NPIN;

    // Register state
    gpr_pins_t   pin_data_q;
    gpr_pins_t   output_direction_q;
    gpr_pins_t   pull_enable_q;
    gpr_pins_t   drive_strength_q;
    gpr_pins_t   edge_or_level_select_q;
    gpr_pins_t   single_or_both_edges_q;
    gpr_pins_t   event_polarity_q;
    gpr_pins_t   interrupt_mask_enable_q;
    gpr_pins_t   raw_int_status_q;
    logic [31:0] capture_select_q;
    gpr_fsel_t   fsel_q [NPIN];

    // Pin sampling and outputs
    gpr_pins_t   pin_q;
    gpr_pins_t   pin_prev_q;
    gpr_pad_t    pad_q;
    logic [31:0] rdata_q;
    logic        irq_q;

    // Decode
    logic        hit;
    logic [7:0]  offset;
    logic        wr;
    logic        rd;
    gpr_pins_t   wpins;
    logic        wr_data;
    logic        wr_dir;
    logic        wr_pull;
    logic        wr_drive;
    logic        wr_sense;
    logic        wr_both;
    logic        wr_pol;
    logic        wr_mask;
    logic        wr_iclr;
    logic        wr_set;
    logic        wr_clr;
    logic        wr_capsel;
    logic [3:0]  wr_fsel;

    gpr_pins_t   port_fn;
    gpr_pins_t   event_hit;
    gpr_pins_t   masked_int_status;
    gpr_pins_t   mux_out;
    gpr_pins_t   mux_oe;
    logic [31:0] fsel_word [4];
    logic [31:0] rdata_d;

    // Anything outside the decoded window is unmapped and reads as zero
    assign hit    = (bus_req_i.addr & DECODE_MASK) == BASE_ADDR; // [RQ1]
    assign offset = bus_req_i.addr[7:0];
    assign wr     = bus_req_i.we && hit;
    assign rd     = bus_req_i.re && hit;
    assign wpins  = bus_req_i.wdata[NPIN-1:0]; // [RQ23]
    assign wr_data   = wr && (offset == `GPR_OFF_DATA);
    assign wr_dir    = wr && (offset == `GPR_OFF_DIR);
    assign wr_pull   = wr && (offset == `GPR_OFF_PULL);
    assign wr_drive  = wr && (offset == `GPR_OFF_DRIVE);
    assign wr_sense  = wr && (offset == `GPR_OFF_SENSE);
    assign wr_both   = wr && (offset == `GPR_OFF_BOTH);
    assign wr_pol    = wr && (offset == `GPR_OFF_POL);
    assign wr_mask   = wr && (offset == `GPR_OFF_MASK);
    assign wr_iclr   = wr && (offset == `GPR_OFF_ICLR);
    assign wr_set    = wr && (offset == `GPR_OFF_SET);
    assign wr_clr    = wr && (offset == `GPR_OFF_CLR);
    assign wr_capsel = wr && (offset == `GPR_OFF_CAPSEL);
    assign wr_fsel[0] = wr && (offset == `GPR_OFF_FSEL0);
    assign wr_fsel[1] = wr && (offset == `GPR_OFF_FSEL1);
    assign wr_fsel[2] = wr && (offset == `GPR_OFF_FSEL2);
    assign wr_fsel[3] = wr && (offset == `GPR_OFF_FSEL3);

    // Output data; a direct write stores every bit, set and clear only
    // touch pins in port function
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            pin_data_q <= `GPR_RST_PINS;
        end else if (wr_data) begin
            pin_data_q <= wpins;
        end else if (wr_set) begin
            pin_data_q <= pin_data_q | (wpins & port_fn); // [RQ17]
        end else if (wr_clr) begin
            pin_data_q <= pin_data_q & ~(wpins & port_fn); // [RQ18]
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            output_direction_q <= `GPR_RST_PINS; // [RQ4]
            pull_enable_q      <= `GPR_RST_PULL; // [RQ5]
            drive_strength_q   <= `GPR_RST_PINS; // [RQ6]
        end else begin
            if (wr_dir) begin
                output_direction_q <= wpins; // [RQ4]
            end
            if (wr_pull) begin
                pull_enable_q <= wpins; // [RQ5]
            end
            if (wr_drive) begin
                drive_strength_q <= wpins; // [RQ6]
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            edge_or_level_select_q  <= `GPR_RST_PINS;
            single_or_both_edges_q  <= `GPR_RST_PINS;
            event_polarity_q        <= `GPR_RST_PINS;
            interrupt_mask_enable_q <= `GPR_RST_PINS;
        end else begin
            if (wr_sense) begin
                edge_or_level_select_q <= wpins; // [RQ7]
            end
            if (wr_both) begin
                single_or_both_edges_q <= wpins; // [RQ8]
            end
            if (wr_pol) begin
                event_polarity_q <= wpins; // [RQ9]
            end
            if (wr_mask) begin
                interrupt_mask_enable_q <= wpins; // [RQ10]
            end
        end
    end

    // Capture encoding is decoded inside the timers, so all 32 bits are kept
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            capture_select_q <= `GPR_RST_WORD; // [RQ19]
        end else if (wr_capsel) begin
            capture_select_q <= bus_req_i.wdata; // [RQ19]
        end
    end

    // Pins are synchronous to clk_i; one stage gives a stable sample
    // and a second gives the previous level for edge detection
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            pin_q      <= `GPR_RST_PINS;
            pin_prev_q <= `GPR_RST_PINS;
        end else begin
            pin_q      <= pin_level_i;
            pin_prev_q <= pin_q;
        end
    end

    genvar p;
    generate
        for (p = 0; p < NPIN; p++) begin : g_pin
            localparam int REG_IDX = p / `GPR_FSEL_PER_REG;
            localparam int FLD_POS =
                (p % `GPR_FSEL_PER_REG) * `GPR_FSEL_STRIDE;
            localparam logic [31:0] RST_WORD =
                (REG_IDX == 1) ? `GPR_RST_FSEL1 : `GPR_RST_WORD;
            localparam gpr_fsel_t FSEL_RST = RST_WORD[FLD_POS +: 3];

            logic rise;
            logic fall;
            logic level_match;
            logic edge_match;

            // Function select field of this pin
            always_ff @(posedge clk_i) begin
                if (!reset_n_i) begin
                    fsel_q[p] <= FSEL_RST; // [RQ15] [RQ16]
                end else if (wr_fsel[REG_IDX]) begin
                    fsel_q[p] <= bus_req_i.wdata[FLD_POS +: 3]; // [RQ14]
                end
            end

            assign port_fn[p] = fsel_q[p] == `GPR_FSEL_PORT; // [RQ14]

            // Unlisted codes leave the pad undriven rather than guess
            always_comb begin
                mux_out[p] = 1'b0;
                mux_oe[p]  = 1'b0;
                case (fsel_q[p])
                    `GPR_FSEL_PORT: begin
                        mux_out[p] = pin_data_q[p]; // [RQ2]
                        mux_oe[p]  = output_direction_q[p]; // [RQ2]
                    end
                    `GPR_FSEL_ALT0: begin
                        mux_out[p] = alt_zero_i.out[p]; // [RQ14]
                        mux_oe[p]  = alt_zero_i.oe[p];
                    end
                    `GPR_FSEL_ALT1: begin
                        mux_out[p] = alt_one_i.out[p]; // [RQ14]
                        mux_oe[p]  = alt_one_i.oe[p];
                    end
                    `GPR_FSEL_ALT2: begin
                        mux_out[p] = alt_two_i.out[p]; // [RQ14]
                        mux_oe[p]  = alt_two_i.oe[p];
                    end
                    default: mux_oe[p] = 1'b0;
                endcase
            end

            // Pin events only count while the pin is in port function
            assign rise        = pin_q[p] && !pin_prev_q[p];
            assign fall        = !pin_q[p] && pin_prev_q[p];
            assign level_match = event_polarity_q[p] ? pin_q[p]
                                                     : !pin_q[p]; // [RQ9]
            assign edge_match  = single_or_both_edges_q[p] ? (rise || fall)
                               : (event_polarity_q[p] ? rise : fall); // [RQ8]
            assign event_hit[p] = port_fn[p] &&
                (edge_or_level_select_q[p] ? level_match
                                           : edge_match); // [RQ7] [RQ20]

            // A new event in the clear cycle wins, so none is lost
            always_ff @(posedge clk_i) begin
                if (!reset_n_i) begin
                    raw_int_status_q[p] <= 1'b0; // [RQ11]
                end else if (event_hit[p]) begin
                    raw_int_status_q[p] <= 1'b1; // [RQ20]
                end else if (wr_iclr && wpins[p]) begin
                    raw_int_status_q[p] <= 1'b0; // [RQ13]
                end
            end
        end
    endgenerate

    assign masked_int_status = raw_int_status_q
                             & interrupt_mask_enable_q; // [RQ21]

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            pad_q <= '0;
            irq_q <= 1'b0;
        end else begin
            pad_q.out        <= mux_out;
            pad_q.oe         <= mux_oe;
            pad_q.pull       <= pull_enable_q;
            pad_q.drive_high <= drive_strength_q;
            irq_q            <= |masked_int_status; // [RQ22]
        end
    end

    // Function select registers as software sees them
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            fsel_word[k] = '0;
        end
        for (int i = 0; i < NPIN; i++) begin
            fsel_word[i / `GPR_FSEL_PER_REG]
                [(i % `GPR_FSEL_PER_REG) * `GPR_FSEL_STRIDE +: 3] = fsel_q[i];
        end
    end

    // Write-only and unmapped offsets read as zero
    always_comb begin
        rdata_d = '0;
        if (!rd) begin
            rdata_d = '0;
        end else if (offset == `GPR_OFF_DATA) begin
            rdata_d = {6'h00, pin_q}; // [RQ3]
        end else if (offset == `GPR_OFF_DIR) begin
            rdata_d = {6'h00, output_direction_q};
        end else if (offset == `GPR_OFF_PULL) begin
            rdata_d = {6'h00, pull_enable_q};
        end else if (offset == `GPR_OFF_DRIVE) begin
            rdata_d = {6'h00, drive_strength_q};
        end else if (offset == `GPR_OFF_SENSE) begin
            rdata_d = {6'h00, edge_or_level_select_q};
        end else if (offset == `GPR_OFF_BOTH) begin
            rdata_d = {6'h00, single_or_both_edges_q};
        end else if (offset == `GPR_OFF_POL) begin
            rdata_d = {6'h00, event_polarity_q};
        end else if (offset == `GPR_OFF_MASK) begin
            rdata_d = {6'h00, interrupt_mask_enable_q};
        end else if (offset == `GPR_OFF_RAW) begin
            rdata_d = {6'h00, raw_int_status_q}; // [RQ11]
        end else if (offset == `GPR_OFF_MASKED) begin
            rdata_d = {6'h00, masked_int_status}; // [RQ12]
        end else if (offset == `GPR_OFF_FSEL0) begin
            rdata_d = fsel_word[0];
        end else if (offset == `GPR_OFF_FSEL1) begin
            rdata_d = fsel_word[1];
        end else if (offset == `GPR_OFF_FSEL2) begin
            rdata_d = fsel_word[2];
        end else if (offset == `GPR_OFF_FSEL3) begin
            rdata_d = fsel_word[3];
        end else if (offset == `GPR_OFF_CAPSEL) begin
            rdata_d = capture_select_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign bus_rdata_o      = rdata_q;
    assign pad_o            = pad_q;
    assign pin_sampled_o    = pin_q;
    assign capture_select_o = capture_select_q;
    assign irq_o            = irq_q;

    // Checks
    dir_reset_in_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        $past(!reset_n_i) |-> (output_direction_q == '0) && (pad_o.oe == '0))
        else $error("direction not input after reset"); // [RQ4]
    pull_reset_on_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        $past(!reset_n_i) |-> pull_enable_q == `GPR_RST_PULL)
        else $error("pulls not enabled after reset"); // [RQ5]
    unmapped_zero_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (bus_req_i.re && !hit) |=> bus_rdata_o == '0)
        else $error("unmapped read not zero"); // [RQ1]
    read_pin_level_a: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        (rd && offset == `GPR_OFF_DATA) |=>
        bus_rdata_o == {6'h00, $past(pin_q)})
        else $error("data read is not pin level"); // [RQ3]
    set_port_bits_a: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        wr_set |=> ((pin_data_q & $past(wpins & port_fn))
                    == $past(wpins & port_fn))
                && ((pin_data_q & ~$past(wpins & port_fn))
                    == ($past(pin_data_q) & ~$past(wpins & port_fn))))
        else $error("set register misbehaves"); // [RQ17]
    clr_port_bits_a: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        wr_clr |=> (pin_data_q & $past(wpins & port_fn)) == '0)
        else $error("clear register misbehaves"); // [RQ18]
    icl_clears_raw_a: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        wr_iclr |=> (raw_int_status_q & $past(wpins & ~event_hit)) == '0)
        else $error("interrupt clear ignored"); // [RQ13]
    event_sets_raw_a: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        (event_hit != '0) |=> (raw_int_status_q & $past(event_hit))
                               == $past(event_hit))
        else $error("event did not set raw status"); // [RQ20]
    masked_read_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (rd && offset == `GPR_OFF_MASKED) |=>
        bus_rdata_o == {6'h00,
                        $past(raw_int_status_q & interrupt_mask_enable_q)})
        else $error("masked status not mask and raw"); // [RQ21]
    irq_follows_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        ((masked_int_status != '0) [*2]) |-> irq_o)
        else $error("interrupt line not raised"); // [RQ22]
    port_drive_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (port_fn[0] && output_direction_q[0]) [*2] |->
        pad_o.out[0] == $past(pin_data_q[0]))
        else $error("port output not driven"); // [RQ2]

endmodule // gpr_top

// ==== tb/gpr_pin_model.sv ====
// Behavioural model of the pins and the outside world driving them.
`include "gpr_cfg.svh"

module gpr_pin_model #(
    parameter logic [25:0] PULL_UP = 26'h000_0E00
) (
    input  wire logic              clk_i,
    input  wire gpr_pkg::gpr_pad_t  pad_i,
    input  wire gpr_pkg::gpr_pins_t ext_en_i,
    input  wire gpr_pkg::gpr_pins_t ext_val_i,
    output gpr_pkg::gpr_pins_t      level_o
);
    timeunit 1ns;
    timeprecision 100ps;
    import gpr_pkg::*;

    gpr_pins_t noise_q = '0;

    // A floating pin must not look stable, so it toggles every cycle
    always @(posedge clk_i) begin
        noise_q <= ~noise_q;
    end

    always_comb begin
        for (int p = 0; p < `GPR_NPIN; p++) begin
            if (ext_en_i[p]) begin
                level_o[p] = ext_val_i[p];
            end else if (pad_i.oe[p]) begin
                level_o[p] = pad_i.out[p];
            end else if (pad_i.pull[p]) begin
                level_o[p] = PULL_UP[p];
            end else begin
                level_o[p] = noise_q[p];
            end
        end
    end
endmodule // gpr_pin_model

// ==== tb/tb.sv ====
// Self-checking bench for the pin port register block.
`include "gpr_cfg.svh"

module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import gpr_pkg::*;

    localparam logic [31:0] BASE = `GPR_BASE_ADDR;

    logic         clk_i;
    logic         reset_n_i;
    gpr_bus_req_t bus_req;
    logic [31:0]  bus_rdata;
    gpr_pins_t    pin_level;
    gpr_pins_t    ext_en;
    gpr_pins_t    ext_val;
    gpr_alt_t     alt0;
    gpr_alt_t     alt1;
    gpr_alt_t     alt2;
    gpr_pad_t     pad;
    gpr_pins_t    sampled;
    logic [31:0]  capsel;
    logic         irq;
    int           mismatches;
    int           checks;

    gpr_top dut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .bus_req_i(bus_req),
        .bus_rdata_o(bus_rdata), .pin_level_i(pin_level),
        .alt_zero_i(alt0), .alt_one_i(alt1), .alt_two_i(alt2),
        .pad_o(pad), .pin_sampled_o(sampled), .capture_select_o(capsel),
        .irq_o(irq)
    );

    gpr_pin_model u_pins (
        .clk_i(clk_i), .pad_i(pad), .ext_en_i(ext_en),
        .ext_val_i(ext_val), .level_o(pin_level)
    );

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic results;
        if (mismatches == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h, expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic wr(input logic [31:0] off, input logic [31:0] d);
        @(posedge clk_i);
        bus_req <= '{addr: BASE + off, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge clk_i);
        bus_req.we <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rc(input logic [31:0] off, input logic [31:0] exp);
        @(posedge clk_i);
        bus_req <= '{addr: BASE + off, wdata: 32'h0, we: 1'b0, re: 1'b1};
        @(posedge clk_i);
        bus_req.re <= 1'b0;
        #1 chk(bus_rdata, exp);
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic pin3(input logic v);
        @(posedge clk_i);
        ext_val <= {22'h0, v, 3'h0};
        wt(3);
    endtask

    task automatic t_reset;
        logic [31:0] e;
        for (int a = 4; a <= 'h44; a += 4) begin
            e = (a == 8) ? 32'h03FF_FFFF :
                (a == 'h30) ? 32'h0000_0110 : 32'h0;
            rc(32'(a), e);
        end
        chk({6'h0, pad.pull}, 32'h03FF_FFFF);
        chk({pad.drive_high, irq, 5'h0}, 32'h0);
    endtask

    task automatic t_data;
        wr(`GPR_OFF_DIR, 32'hFFFF_FFFF);
        rc(`GPR_OFF_DIR, 32'h03FF_FFFF);
        wr(`GPR_OFF_DATA, 32'h0155_5555);
        wr(`GPR_OFF_SET, 32'h0000_0202);
        wr(`GPR_OFF_CLR, 32'h0000_0401);
        wt(2);
        chk({6'h0, pad.out}, 32'h0155_5756);
        chk({6'h0, pad.oe}, 32'h03FF_FFFF);
        rc(`GPR_OFF_DATA, 32'h0155_5756);
        wr(`GPR_OFF_FSEL1, 32'h0);
        wt(2);
        chk({6'h0, pad.out}, 32'h0155_5556);
        wr(`GPR_OFF_DIR, 32'h03FF_FF00);
        wt(3);
        chk({6'h0, pad.oe}, 32'h03FF_FF00);
        rc(`GPR_OFF_DATA, 32'h0155_5500);
        chk({6'h0, sampled}, 32'h0155_5500);
    endtask

    task automatic t_fsel;
        logic [2:0] code [5];
        logic [3:0] exp [5];
        code = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h2};
        // Out and enable of pin 17, then of pin 24
        exp = '{4'h7, 4'hF, 4'h5, 4'hA, 4'h0};
        for (int i = 0; i < 5; i++) begin
            wr(`GPR_OFF_FSEL2, {25'h0, code[i], 4'h0});
            wr(`GPR_OFF_FSEL3, {29'h0, code[i]});
            wt(2);
            chk({28'h0, pad.out[17], pad.oe[17], pad.out[24],
                 pad.oe[24]}, {28'h0, exp[i]});
            rc(`GPR_OFF_FSEL3, {29'h0, code[i]});
        end
        wr(`GPR_OFF_FSEL2, 32'h0);
        wr(`GPR_OFF_FSEL3, 32'h0);
    endtask

    task automatic t_irq;
        logic [2:0] cfg [5];
        logic [3:0] ex [5];
        // Sense, both edges, polarity: fall, rise, both, low, high
        cfg = '{3'b000, 3'b001, 3'b010, 3'b100, 3'b101};
        // Raw bit seen after: clear at low, rise, clear at high, fall
        ex = '{4'b0001, 4'b0100, 4'b0101, 4'b1101, 4'b0111};
        @(posedge clk_i);
        ext_en <= 26'h000_0008;
        wr(`GPR_OFF_MASK, 32'h8);
        // Earlier scenarios left falling-edge events on other pins
        wr(`GPR_OFF_ICLR, 32'hFFFF_FFFF);
        for (int i = 0; i < 5; i++) begin
            pin3(1'b0);
            wr(`GPR_OFF_SENSE, {28'h0, cfg[i][2], 3'h0});
            wr(`GPR_OFF_BOTH, {28'h0, cfg[i][1], 3'h0});
            wr(`GPR_OFF_POL, {28'h0, cfg[i][0], 3'h0});
            wr(`GPR_OFF_ICLR, 32'h8);
            rc(`GPR_OFF_RAW, {28'h0, ex[i][3], 3'h0});
            pin3(1'b1);
            rc(`GPR_OFF_RAW, {28'h0, ex[i][2], 3'h0});
            rc(`GPR_OFF_MASKED, {28'h0, ex[i][2], 3'h0});
            chk({31'h0, irq}, {31'h0, ex[i][2]});
            wr(`GPR_OFF_ICLR, 32'h8);
            rc(`GPR_OFF_RAW, {28'h0, ex[i][1], 3'h0});
            pin3(1'b0);
            rc(`GPR_OFF_RAW, {28'h0, ex[i][0], 3'h0});
        end
        wr(`GPR_OFF_MASK, 32'h0);
        wr(`GPR_OFF_RAW, 32'h0);
        wr(`GPR_OFF_ICLR, 32'hFFFF_FFF7);
        rc(`GPR_OFF_MASKED, 32'h0);
        rc(`GPR_OFF_RAW, 32'h8);
        chk({31'h0, irq}, 32'h0);
    endtask

    task automatic t_misc;
        wr(`GPR_OFF_DRIVE, 32'hFFFF_FFFF);
        wr(`GPR_OFF_PULL, 32'h0);
        wr(`GPR_OFF_CAPSEL, 32'hA5A5_A5A5);
        wt(2);
        chk({6'h0, pad.drive_high}, 32'h03FF_FFFF);
        chk({6'h0, pad.pull}, 32'h0);
        chk(capsel, 32'hA5A5_A5A5);
        rc(`GPR_OFF_DRIVE, 32'h03FF_FFFF);
        rc(`GPR_OFF_CAPSEL, 32'hA5A5_A5A5);
        // Outside the window or at an unmapped offset: must neither alias nor answer
        wr(32'h0000_0104, 32'h0);
        rc(`GPR_OFF_DIR, 32'h03FF_FF00);
        rc(32'h0000_0100, 32'h0);
        rc(32'h0000_0048, 32'h0);
    endtask

    initial begin
        mismatches = 0;
        checks = 0;
        bus_req = '0;
        reset_n_i = 1'b0;
        ext_en = '0;
        ext_val = '0;
        alt0 = '{out: '0, oe: '1};
        alt1 = '{out: '1, oe: '1};
        alt2 = '{out: '1, oe: '0};
        repeat (20) @(posedge clk_i);
        reset_n_i <= 1'b1;
        t_reset;
        t_data;
        t_fsel;
        t_irq;
        t_misc;
        results;
    end

    // The whole run needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        results;
    end
endmodule // tb
